// >>> wsm_pkg.sv
// Purpose: Shared constants for the store/literal-multiply decode block
// Assumes: 16-bit instruction words, 8-bit data path, four-phase cycle
// Notes: Opcode fields occupy the upper byte of the instruction word
package wsm_pkg;
  localparam int WSM_DATA_W = 8;
  localparam int WSM_ADDR_W = 8;
  localparam int WSM_INSN_W = 16;
  localparam int WSM_PROD_W = 16;
  localparam int WSM_OPC_HI = 15;
  localparam int WSM_OPC_LO = 8;
  localparam logic [7:0] WSM_OPC_STORE = 8'h01;
  localparam logic [7:0] WSM_OPC_MULLIT = 8'hBC;
  localparam logic [7:0] WSM_WORK_RST = 8'h00;
  localparam logic [15:0] WSM_PROD_RST = 16'h0000;

  // Four phases of one instruction cycle
  typedef enum logic [1:0]
  {
    WSM_PH_DECODE = 2'b00,
    WSM_PH_READ = 2'b01,
    WSM_PH_PROC = 2'b10,
    WSM_PH_WRITE = 2'b11
  } wsm_phase_type;

  // Operation chosen at decode
  typedef enum logic [1:0]
  {
    WSM_OP_NONE = 2'b00,
    WSM_OP_STORE = 2'b01,
    WSM_OP_MULLIT = 2'b10
  } wsm_op_type;
endpackage

// >>> wsm_core.sv
// Purpose: Decode and execute store-working-to-file and multiply-literal-working
// Assumes: Fetch stage holds insn_word stable across the four phases of a cycle
// Notes: Phase counter free-runs from reset; one instruction per four clocks
// Function
// RULE_01 - Word 0x01ff decodes as store working register, low byte is address
// RULE_02 - Store copies working register to any of 256 bytes, flags untouched
// RULE_03 - Word 0xBCkk decodes as literal multiply with literal k as operand
// RULE_04 - Product is unsigned working register times unsigned literal
// RULE_05 - 16-bit product: high byte to product high, low byte to product low
// RULE_06 - Literal multiply leaves working register and all status flags unchanged
// RULE_07 - A zero product is not flagged; zero flag keeps its value
// RULE_08 - Each operation completes in four phases, result written in last phase
`timescale 1ns/100ps
module wsm_core
  import wsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WSM_INSN_W-1:0] insn_word,
  input wire logic [WSM_DATA_W-1:0] working_register,
  input wire logic [7:0] status_in,
  output logic [1:0] phase,
  output logic file_we,
  output logic [WSM_ADDR_W-1:0] file_addr,
  output logic [WSM_DATA_W-1:0] file_wdata,
  output logic [WSM_DATA_W-1:0] product_high_byte,
  output logic [WSM_DATA_W-1:0] product_low_byte,
  output logic [7:0] status_out,
  output logic status_we
);
  // Sequencer register and the value it takes at the next edge
  wsm_phase_type phase_r;
  wsm_phase_type phase_nxt;
  // Operation chosen in the decode phase, held for the rest of the cycle
  wsm_op_type op_r;
  wsm_op_type op_nxt;
  // Low byte of the word: file address for a store, literal for a multiply
  logic [7:0] operand_r;
  // Working register copy; the block reads it and never writes it back
  logic [WSM_DATA_W-1:0] work_r;
  // Full product of the two operand copies
  logic [WSM_PROD_W-1:0] prod_nxt;
  // Product register pair, one flop group per byte
  logic [WSM_DATA_W-1:0] prod_hi_r;
  logic [WSM_DATA_W-1:0] prod_lo_r;
  // Store request towards the data file
  logic file_we_r;
  logic [WSM_ADDR_W-1:0] file_addr_r;
  logic [WSM_DATA_W-1:0] file_wdata_r;
  // Status path
  logic [7:0] status_r;
  logic status_we_r;
  // Phase and opcode decodes shared by several processes
  logic in_decode;
  logic in_read;
  logic in_proc;
  logic mul_in_proc;
  logic store_in_proc;
  logic [7:0] opcode;

  // Shared decodes; kept apart so every process tests the same condition
  assign in_decode = (phase_r == WSM_PH_DECODE);
  assign in_read = (phase_r == WSM_PH_READ);
  assign in_proc = (phase_r == WSM_PH_PROC);
  assign mul_in_proc = in_proc && (op_r == WSM_OP_MULLIT);
  assign store_in_proc = in_proc && (op_r == WSM_OP_STORE);
  assign opcode = insn_word[WSM_OPC_HI:WSM_OPC_LO];

  // Next phase: a plain ring of four, so every instruction takes one cycle
  always_comb
  begin
    case (phase_r)
      WSM_PH_DECODE: phase_nxt = WSM_PH_READ;
      WSM_PH_READ: phase_nxt = WSM_PH_PROC;
      WSM_PH_PROC: phase_nxt = WSM_PH_WRITE;
      WSM_PH_WRITE: phase_nxt = WSM_PH_DECODE; // [RULE_08]
      default: phase_nxt = WSM_PH_DECODE;
    endcase
  end

  // Sequencer; reset parks it at decode so the first word is taken at once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_r <= WSM_PH_DECODE;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  // Opcode byte classifier; any other byte belongs to another unit
  always_comb
  begin
    case (opcode)
      WSM_OPC_STORE: op_nxt = WSM_OP_STORE; // [RULE_01]
      WSM_OPC_MULLIT: op_nxt = WSM_OP_MULLIT; // [RULE_03]
      default: op_nxt = WSM_OP_NONE;
    endcase
  end

  // Decode register, loaded only in the first phase so a late word cannot retarget it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_r <= WSM_OP_NONE;
    end
    else if (in_decode)
    begin
      op_r <= op_nxt;
    end
  end

  // Operand byte taken in the read phase; one field serves as address and literal
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      operand_r <= 8'h00;
    end
    else if (in_read)
    begin
      operand_r <= insn_word[7:0]; // [RULE_01] [RULE_03]
    end
  end

  // Working register copy taken in the read phase, never written back
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      work_r <= WSM_WORK_RST;
    end
    else if (in_read)
    begin
      work_r <= working_register; // [RULE_02] [RULE_06]
    end
  end

  // Zero-extended operands keep the multiply unsigned; 8 x 8 always fits 16 bits
  always_comb
  begin
    prod_nxt = WSM_PROD_W'({8'h00, work_r} * {8'h00, operand_r}); // [RULE_04]
  end

  // Product high byte; loaded at the close of the process phase, seen in write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prod_hi_r <= WSM_PROD_RST[15:8];
    end
    else if (mul_in_proc)
    begin
      prod_hi_r <= prod_nxt[15:8]; // [RULE_05] [RULE_08]
    end
  end

  // Product low byte; a store leaves the pair alone
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prod_lo_r <= WSM_PROD_RST[7:0];
    end
    else if (mul_in_proc)
    begin
      prod_lo_r <= prod_nxt[7:0]; // [RULE_05] [RULE_08]
    end
  end

  // Store strobe: one clock wide, covering exactly the write phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      file_we_r <= 1'b0;
    end
    else
    begin
      file_we_r <= store_in_proc; // [RULE_08]
    end
  end

  // Address and data hold after the strobe so the file side may sample late
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      file_addr_r <= 8'h00;
      file_wdata_r <= 8'h00;
    end
    else if (store_in_proc)
    begin
      file_addr_r <= operand_r; // [RULE_02]
      file_wdata_r <= work_r; // [RULE_02]
    end
  end

  // Status pass-through; flags are only ever carried, never rewritten
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_r <= 8'h00;
    end
    else
    begin
      status_r <= status_in; // [RULE_06] [RULE_07]
    end
  end

  // Flag write request stays low: no flag moves, not even for a zero product
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_we_r <= 1'b0;
    end
    else
    begin
      status_we_r <= 1'b0; // [RULE_06] [RULE_07]
    end
  end

  // Every output is a flop; the product pair changes only after a multiply
  assign product_high_byte = prod_hi_r; // [RULE_05]
  assign product_low_byte = prod_lo_r; // [RULE_05]
  assign phase = phase_r;
  assign file_we = file_we_r;
  assign file_addr = file_addr_r;
  assign file_wdata = file_wdata_r;
  assign status_out = status_r;
  assign status_we = status_we_r; // [RULE_06] [RULE_07]
endmodule

// >>> wsm_core_props.sv
// Purpose: Checks on the wsm_core port timing
// Assumes: Opcode taken at phase 0, working register at phase 1
// Notes: Result checked three edges after decode
`timescale 1ns/100ps
module wsm_core_props
  import wsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic file_we,
  input wire logic status_we,
  input wire logic [15:0] insn_word,
  input wire logic [1:0] phase,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_in,
  input wire logic [7:0] status_out,
  input wire logic [7:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] product_high_byte,
  input wire logic [7:0] product_low_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_st;
    phase == 2'h0 && insn_word[15:8] == WSM_OPC_STORE;
  endsequence
  sequence s_mul;
    phase == 2'h0 && insn_word[15:8] == WSM_OPC_MULLIT;
  endsequence
  AST_STORE_ADDR: assert property (s_st |-> ##3
    file_we && file_addr == $past(insn_word[7:0], 2))
    else $error("store address wrong");
  AST_STORE_DATA: assert property (s_st ##1 1 |-> ##2 file_wdata == $past(working_register, 2))
    else $error("store data wrong");
  AST_OTHER_NO_WE: assert property (phase == 2'h0 &&
    insn_word[15:8] != WSM_OPC_STORE |-> ##3 !file_we)
    else $error("stray file write");
  AST_STORE_NO_PROD: assert property (s_st |-> ##3
    $stable({product_high_byte, product_low_byte}))
    else $error("store moved product");
  AST_MUL_PROD: assert property (s_mul ##1 1 |-> ##2
    {product_high_byte, product_low_byte} ==
    16'($past(insn_word[7:0], 2)) * 16'($past(working_register, 2)))
    else $error("product wrong");
  AST_PROD_HOLD: assert property (phase != 2'h3 |-> $stable({product_high_byte, product_low_byte}))
    else $error("product moved outside write phase");
  AST_STATUS_KEEP: assert property (!$past(rst) |-> status_out == $past(status_in) && !status_we)
    else $error("status altered");
  AST_ZERO_QUIET: assert property (s_mul ##0 insn_word[7:0] == 8'h00 |-> ##3
    !status_we && status_out == $past(status_in))
    else $error("zero product flagged");
  AST_PHASE_STEP: assert property (!$past(rst) |-> phase == 2'($past(phase) + 2'h1))
    else $error("phase skipped");
endmodule
bind wsm_core wsm_core_props chk_u (.*);

// >>> wsm_file_model.sv
// Purpose: Data file that absorbs stores from wsm_core
// Assumes: One write a cycle
// Notes: Reads are done by the bench directly
`timescale 1ns/100ps
module wsm_file_model
(
  input wire logic clk,
  input wire logic file_we,
  input wire logic [7:0] file_addr,
  input wire logic [7:0] file_wdata
);
  logic [7:0] mem [256];
  // Any of the 256 bytes may be written
  always_ff @(posedge clk) if (file_we) mem[file_addr] <= file_wdata;
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for wsm_core
// Assumes: Inputs held for the whole four-phase cycle
// Notes: Corner words first, then xorshift words
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, file_we, status_we;
  logic [15:0] insn_word = 16'h0000, p_e = 16'h0000;
  logic [7:0] working_register = 8'h00, status_in = 8'h00, status_out, file_addr, file_wdata;
  logic [7:0] product_high_byte, product_low_byte;
  logic [1:0] phase;
  logic [31:0] seed = 32'h0000AF5D, r;
  int fails = 0, checks = 0;
  wsm_core dut_u (.clk, .rst, .insn_word, .working_register, .status_in, .phase, .file_we,
    .file_addr, .file_wdata, .product_high_byte, .product_low_byte, .status_out, .status_we);
  wsm_file_model fm_u (.clk, .file_we, .file_addr, .file_wdata);
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Expected product: both bytes unsigned, all 16 bits kept
  function automatic logic [15:0] exp_prod(input logic [7:0] a, input logic [7:0] b);
    return 16'(a) * 16'(b);
  endfunction
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One instruction: present at phase 0, nothing visible before phase 3
  task automatic run(input logic [15:0] iw, input logic [7:0] w);
    insn_word = iw;
    working_register = w;
    status_in = 8'(rnd());
    repeat (2) @(posedge clk);
    #1;
    chk({product_high_byte, product_low_byte} === p_e && file_we === 1'b0, "early");
    @(posedge clk);
    #1;
    if (iw[15:8] == 8'hBC) p_e = exp_prod(w, iw[7:0]);
    chk(phase === 2'h3, "phase");
    chk(file_we === (iw[15:8] == 8'h01), "write strobe");
    if (iw[15:8] == 8'h01) chk(file_addr === iw[7:0], "store address");
    chk({product_high_byte, product_low_byte} === p_e, "product");
    chk(status_out === status_in && status_we === 1'b0, "status");
    @(posedge clk);
    #1;
    if (iw[15:8] == 8'h01) chk(fm_u.mem[iw[7:0]] === w && file_wdata === w, "data");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    run(16'h01FF, 8'h4F);
    run(16'h0100, 8'hA5);
    run(16'hBCFF, 8'hFF);
    run(16'hBC00, 8'h37);
    run(16'hBCC4, 8'hE2);
    // Mid-run reset with a nonzero product and held store data: all return to rest
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(phase === 2'h0 && file_we === 1'b0 && status_we === 1'b0, "reset state");
    chk({file_addr, file_wdata} === 16'h0000 && status_out === 8'h00, "reset store");
    chk({product_high_byte, product_low_byte} === 16'h0000, "reset product");
    p_e = 16'h0000;
    rst = 1'b0;
    run(16'hBC55, 8'h00);
    run(16'hB0AA, 8'h11);
    repeat (60)
    begin
      r = rnd();
      run({r[9:8] == 2'h0 ? 8'h01 : r[9:8] == 2'h1 ? 8'hBC : r[23:16], r[7:0]}, r[31:24]);
    end
    stop_test();
  end
  // Watchdog well beyond 67 instructions of 40 ns plus the resets
  initial
  begin
    #20000;
    fails++;
    stop_test();
  end
endmodule
